// ---- design/completion_coalescer.sv ----
`timescale 1ns/1ps
module completion_coalescer (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire coalesce_pkg::completion_t completion,
    input wire coalesce_pkg::doorbell_t doorbell,
    input wire logic [7:0] critical_warning,
    output logic [coalesce_pkg::NUM_VEC-1:0] vector_irq,
    output logic admin_irq,
    output logic async_event,
    output logic [7:0] async_event_bits,
    output logic admin_done
);
    import coalesce_pkg::*;

    logic [7:0] agg_time_q;
    logic [7:0] thresh_q;
    logic [7:0] mask_q;
    logic [NUM_VEC-1:0] off_q;
    logic [31:0] dw11_q;
    logic [7:0] fid_q;
    logic [31:0] result_q;
    logic bad_fid_q;
    logic [11:0] tick_cnt_q;
    logic tick_q;
    logic [7:0] warn_s1_q;
    logic [7:0] warn_s2_q;
    logic [7:0] warn_s3_q;
    logic [7:0] warn_prev_q;
    logic [NUM_VEC-1:0] fire;

    logic wr;
    logic rd;
    logic cmd_go;
    logic cmd_set;
    logic [7:0] cmd_fid;
    logic fid_coal;
    logic fid_vec;
    logic fid_evt;
    logic fid_ok;
    logic [VEC_W-1:0] sel_vec;
    logic vec_in_range;
    logic [7:0] warn_rise;
    logic [7:0] warn_stable;
    logic [31:0] get_word;
    logic [31:0] read_mux;
    logic addr_ok;

    function automatic logic is_fid(input logic [7:0] f, input logic [7:0] id);
        return f == id;
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign cmd_go = wr && paddr == ADDR_CMD && pwdata[CMD_GO_BIT];
    assign cmd_set = pwdata[CMD_SET_BIT];
    assign cmd_fid = pwdata[7:0];
    assign fid_coal = is_fid(cmd_fid, FID_COALESCE);
    assign fid_vec = is_fid(cmd_fid, FID_VECTOR_CFG);
    assign fid_evt = is_fid(cmd_fid, FID_EVENT_CFG);
    assign fid_ok = fid_coal || fid_vec || fid_evt;
    assign sel_vec = dw11_q[VEC_FLD_LSB +: VEC_W];
    assign vec_in_range = dw11_q[15:VEC_W] == '0;

    // get words carry only defined fields, reserved positions zero
    assign get_word = fid_coal ? {16'h0000, agg_time_q, thresh_q} :
                      fid_vec ? {15'h0000, off_q[sel_vec], dw11_q[15:0]} :
                      fid_evt ? {24'h000000, mask_q} : 32'h0000_0000;

    assign addr_ok = paddr == ADDR_CMD || paddr == ADDR_DW11 || paddr == ADDR_RESULT ||
                     paddr == ADDR_STATUS || paddr == ADDR_WARN;
    assign read_mux = paddr == ADDR_CMD ? {24'h000000, fid_q} :
                      paddr == ADDR_DW11 ? dw11_q :
                      paddr == ADDR_RESULT ? result_q :
                      paddr == ADDR_STATUS ? {23'h000000, bad_fid_q, fire} :
                      paddr == ADDR_WARN ? {24'h000000, warn_prev_q} : 32'h0000_0000;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !pready;
            pslverr <= psel && !pready && !addr_ok;
            prdata <= read_mux;
        end
    end

    logic acc;
    assign acc = psel && penable && pready;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            dw11_q <= 32'h0000_0000;
        else if (acc && pwrite && paddr == ADDR_DW11)
            dw11_q <= pwdata;
    end

    // feature settings and command completion
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            agg_time_q <= TIME_RESET;
            thresh_q <= THRESH_RESET;
            mask_q <= MASK_RESET;
            off_q <= '0;
            fid_q <= 8'h00;
            result_q <= 32'h0000_0000;
            bad_fid_q <= 1'b0;
            admin_done <= 1'b0;
        end
        else
        begin
            admin_done <= acc && cmd_go;
            if (acc && cmd_go)
            begin
                fid_q <= cmd_fid;
                bad_fid_q <= !fid_ok;
                result_q <= cmd_set ? 32'h0000_0000 : get_word;
                if (cmd_set && fid_coal)
                begin
                    agg_time_q <= dw11_q[TIME_LSB +: 8];
                    thresh_q <= dw11_q[THRESH_LSB +: 8];
                end
                if (cmd_set && fid_vec && vec_in_range)
                    off_q[sel_vec] <= dw11_q[OFF_FLAG_BIT];
                if (cmd_set && fid_evt)
                    mask_q <= dw11_q[MASK_LSB +: 8];
            end
        end
    end

    // one shared 100us tick serves all vectors
    always_ff @(posedge clk_sys)
    begin
        if (reset || tick_cnt_q == TICK_LAST)
            tick_cnt_q <= 12'h000;
        else
            tick_cnt_q <= tick_cnt_q + 12'h001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            tick_q <= 1'b0;
        else
            tick_q <= tick_cnt_q == TICK_LAST;
    end

    genvar v;
    generate
        for (v = 0; v < NUM_VEC; v++)
        begin : g_vec
            logic post_v;
            logic ring_v;
            assign post_v = completion.valid && !completion.admin && completion.vector == VEC_W'(v);
            assign ring_v = doorbell.valid && doorbell.vector == VEC_W'(v);
            vector_aggregator u_agg (
                .clk_sys(clk_sys),
                .reset(reset),
                .tick(tick_q),
                .post(post_v),
                .urgent(completion.error),
                .restart(ring_v && !post_v),
                .off_flag(off_q[v]),
                .agg_time(agg_time_q),
                .entry_count_trigger(thresh_q),
                .fire(fire[v])
            );
        end
    endgenerate

    assign vector_irq = fire;

    // admin queue bypasses aggregation entirely
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            admin_irq <= 1'b0;
        else
            admin_irq <= completion.valid && completion.admin;
    end

    // warning inputs come from another domain
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            warn_s1_q <= 8'h00;
            warn_s2_q <= 8'h00;
            warn_s3_q <= 8'h00;
        end
        else
        begin
            warn_s1_q <= critical_warning;
            warn_s2_q <= warn_s1_q;
            warn_s3_q <= warn_s2_q;
        end
    end

    assign warn_stable = (warn_s2_q & warn_s3_q) | (warn_prev_q & (warn_s2_q | warn_s3_q));
    assign warn_rise = warn_stable & ~warn_prev_q;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            warn_prev_q <= 8'h00;
            async_event <= 1'b0;
            async_event_bits <= 8'h00;
        end
        else
        begin
            warn_prev_q <= warn_stable;
            async_event <= |(warn_rise & mask_q);
            async_event_bits <= warn_rise & mask_q;
        end
    end

    a_admin_direct: assert property (@(posedge clk_sys) disable iff (reset)
        completion.valid && completion.admin |=> admin_irq) else $error("admin interrupt delayed");
    a_urgent_fires: assert property (@(posedge clk_sys) disable iff (reset)
        completion.valid && !completion.admin && completion.error |=> vector_irq[$past(completion.vector)])
        else $error("error completion held back");
    a_set_done: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go |=> admin_done) else $error("no completion after command");
    a_set_result: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go && cmd_set |=> result_q == 32'h0000_0000) else $error("set left a result word");
    a_bad_fid: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go && !fid_ok |=> bad_fid_q && result_q == 32'h0000_0000)
        else $error("unknown feature not flagged");
    a_mask_block: assert property (@(posedge clk_sys) disable iff (reset)
        async_event |-> |($past(mask_q) & async_event_bits)) else $error("masked event sent");
    a_no_mask_event: assert property (@(posedge clk_sys) disable iff (reset)
        mask_q == 8'h00 |=> !async_event) else $error("event sent with empty mask");
    a_set_mask: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go && cmd_set && fid_evt |=> mask_q == $past(dw11_q[7:0]))
        else $error("event mask set failed");
    a_get_mask: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go && !cmd_set && fid_evt |=> result_q[31:8] == 24'h000000 && result_q[7:0] == mask_q)
        else $error("event mask readback wrong");
    a_coal_readback: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go && !cmd_set && fid_coal |=> result_q == {16'h0000, agg_time_q, thresh_q})
        else $error("coalescing readback wrong");
    a_set_coal: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go && cmd_set && fid_coal |=> agg_time_q == $past(dw11_q[15:8]) && thresh_q == $past(dw11_q[7:0]))
        else $error("coalescing set failed");
    a_set_vec: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go && cmd_set && fid_vec && vec_in_range |=> off_q[$past(sel_vec)] == $past(dw11_q[OFF_FLAG_BIT]))
        else $error("vector flag set failed");
    a_vec_range: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go && cmd_set && fid_vec && !vec_in_range |=> $stable(off_q))
        else $error("out of range vector changed a flag");
    a_get_vec: assert property (@(posedge clk_sys) disable iff (reset)
        acc && cmd_go && !cmd_set && fid_vec |=> result_q[31:17] == 15'h0000 && result_q[16] == off_q[$past(sel_vec)])
        else $error("vector readback wrong");
    a_tick_single: assert property (@(posedge clk_sys) disable iff (reset)
        tick_q |=> !tick_q) else $error("tick longer than one cycle");
    a_pready_two: assert property (@(posedge clk_sys) disable iff (reset)
        psel && !penable |=> ##[0:1] pready) else $error("apb answer late");
    c_vec_irq: cover property (@(posedge clk_sys) disable iff (reset) |vector_irq);
    c_event: cover property (@(posedge clk_sys) disable iff (reset) async_event);
    c_set_vec: cover property (@(posedge clk_sys) disable iff (reset) acc && cmd_go && cmd_set && fid_vec);
    c_timer_fire: cover property (@(posedge clk_sys) disable iff (reset) tick_q ##1 |vector_irq);
    c_bad_fid: cover property (@(posedge clk_sys) disable iff (reset) acc && cmd_go && !fid_ok);
endmodule // completion_coalescer

// ---- common/coalesce_pkg.sv ----
package coalesce_pkg;
    localparam int NUM_VEC = 8;
    localparam int VEC_W = 3;
    localparam logic [7:0] FID_COALESCE = 8'h08;
    localparam logic [7:0] FID_VECTOR_CFG = 8'h09;
    localparam logic [7:0] FID_EVENT_CFG = 8'h0b;
    localparam int TIME_LSB = 8;
    localparam int THRESH_LSB = 0;
    localparam int VEC_FLD_LSB = 0;
    localparam int OFF_FLAG_BIT = 16;
    localparam int MASK_LSB = 0;
    localparam logic [7:0] TIME_RESET = 8'h00;
    localparam logic [7:0] THRESH_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int CLK_MHZ = 25;
    localparam int TIME_UNIT_US = 100;
    localparam int TICK_CYCLES = TIME_UNIT_US * CLK_MHZ;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
    // apb map
    localparam logic [11:0] ADDR_CMD = 12'h000;
    localparam logic [11:0] ADDR_DW11 = 12'h004;
    localparam logic [11:0] ADDR_RESULT = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam logic [11:0] ADDR_WARN = 12'h010;
    localparam int CMD_GO_BIT = 8;
    localparam int CMD_SET_BIT = 9;

    typedef struct packed {
        logic valid;
        logic admin;
        logic error;
        logic [VEC_W-1:0] vector;
    } completion_t;

    typedef struct packed {
        logic valid;
        logic [VEC_W-1:0] vector;
    } doorbell_t;
endpackage

// ---- design/vector_aggregator.sv ----
`timescale 1ns/1ps
module vector_aggregator (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic tick,
    input wire logic post,
    input wire logic urgent,
    input wire logic restart,
    input wire logic off_flag,
    input wire logic [7:0] agg_time,
    input wire logic [7:0] entry_count_trigger,
    output logic fire
);
    import coalesce_pkg::*;
    logic [8:0] count_q;
    logic [7:0] age_q;
    logic pending;
    logic count_hit;
    logic time_hit;
    logic fire_now;

    assign pending = count_q != 9'h000;
    assign count_hit = (count_q + 9'(post)) >= ({1'b0, entry_count_trigger} + 9'h001);
    // zero time means the timer never forces nor holds
    assign time_hit = pending && agg_time != 8'h00 && tick && (age_q + 8'h01 >= agg_time);
    assign fire_now = (post && (urgent || off_flag)) || ((post || pending) && (count_hit || time_hit));

    always_ff @(posedge clk_sys)
    begin
        if (reset || fire_now || restart)
        begin
            count_q <= 9'h000;
            age_q <= 8'h00;
        end
        else
        begin
            if (post)
                count_q <= count_q + 9'h001;
            if (pending && tick)
                age_q <= age_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            fire <= 1'b0;
        else
            fire <= fire_now;
    end

    a_bypass_fires: assert property (@(posedge clk_sys) disable iff (reset)
        post && off_flag |=> fire) else $error("disabled vector did not fire");
    a_count_fires: assert property (@(posedge clk_sys) disable iff (reset)
        post && !restart && count_q == {1'b0, entry_count_trigger} |=> fire) else $error("threshold missed");
    a_no_early: assert property (@(posedge clk_sys) disable iff (reset)
        post && !urgent && !off_flag && !tick && count_q + 9'h001 < {1'b0, entry_count_trigger} + 9'h001
        |=> !fire) else $error("fired early");
endmodule // vector_aggregator

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic hung
);
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, hung} = '0;
    end

    // one apb transfer, entered just after a rising edge; holds the request until pready is seen or 32 cycles pass
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        logic ok;
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // pready, prdata and pslverr are taken at the rising edge that ends the access
        do
        begin
            @(posedge clk_sys);
            n++;
            ok = pready;
        end
        while (ok !== 1'b1 && n < 32);
        r = prdata;
        e = pslverr;
        hung <= (ok !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule // host_model

// ---- tb/test_completion_coalescer.sv ----
`timescale 1ns/1ps
module test_completion_coalescer;
    import coalesce_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, admin_irq, async_event, admin_done, hung, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, res;
    logic [7:0] critical_warning = 8'h00;
    logic [7:0] vector_irq, async_event_bits, irq_acc, ev_acc;
    completion_t completion = '0;
    doorbell_t doorbell = '0;
    int failures = 0;
    int n_tests = 0;
    int n_admin = 0;
    int n_done = 0;
    logic clear = 1'b0;

    always #20 clk_sys = ~clk_sys;

    // sticky record of every pulse since the last clear
    always @(posedge clk_sys)
    begin
        if (clear)
        begin
            irq_acc <= 8'h00;
            ev_acc <= 8'h00;
            n_admin <= 0;
            n_done <= 0;
        end
        else
        begin
            irq_acc <= irq_acc | vector_irq;
            ev_acc <= ev_acc | (async_event ? async_event_bits : 8'h00);
            n_admin <= n_admin + int'(admin_irq);
            n_done <= n_done + int'(admin_done);
        end
    end

    completion_coalescer uut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .completion(completion), .doorbell(doorbell),
        .critical_warning(critical_warning), .vector_irq(vector_irq), .admin_irq(admin_irq),
        .async_event(async_event), .async_event_bits(async_event_bits), .admin_done(admin_done));

    host_model host (.clk_sys(clk_sys), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge hung)
    begin
        failures++;
        report_and_stop();
    end

    // feature command: dword 11, then go, then fetch the result word
    task automatic cmd(input logic set, input logic [7:0] fid, input logic [31:0] dw);
        host.xfer(1'b1, ADDR_DW11, dw, res, err);
        host.xfer(1'b1, ADDR_CMD, {22'h0, set, 1'b1, fid}, res, err);
        host.xfer(1'b0, ADDR_RESULT, 32'h0, res, err);
    endtask

    task automatic clr();
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
    endtask

    task automatic post(input logic adm, input logic er, input logic [2:0] v, input int k);
        repeat (k)
        begin
            completion <= {1'b1, adm, er, v};
            @(posedge clk_sys);
        end
        completion <= '0;
        repeat (3) @(posedge clk_sys);
    endtask

    initial
    begin
        int n;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        clr();
        cmd(1'b0, FID_COALESCE, 32'hffff_ffff);
        chk("coalesce reset", res, 32'h0);
        cmd(1'b0, FID_EVENT_CFG, 32'h0);
        chk("mask reset", res, 32'h0);
        cmd(1'b0, FID_VECTOR_CFG, 32'h3);
        chk("vector default", res, 32'h3);
        clr();
        cmd(1'b1, FID_COALESCE, 32'hffff_ff02);
        chk("set done", 32'(n_done), 32'h1);
        cmd(1'b0, FID_COALESCE, 32'h0);
        chk("coalesce readback", res, 32'h0000_ff02);
        clr();
        post(1'b0, 1'b0, 3'd1, 2);
        chk("two held", 32'(irq_acc), 32'h0);
        post(1'b0, 1'b0, 3'd1, 1);
        chk("third fires", 32'(irq_acc), 32'h2);
        clr();
        post(1'b0, 1'b0, 3'd1, 2);
        doorbell <= {1'b1, 3'd1};
        @(posedge clk_sys);
        doorbell <= '0;
        post(1'b0, 1'b0, 3'd1, 2);
        post(1'b1, 1'b0, 3'd0, 1);
        chk("doorbell restart", 32'(irq_acc), 32'h0);
        chk("admin direct", 32'(n_admin), 32'h1);
        post(1'b0, 1'b1, 3'd4, 1);
        chk("error direct", 32'(irq_acc), 32'h10);
        cmd(1'b1, FID_VECTOR_CFG, 32'hfffe_0005);
        cmd(1'b1, FID_VECTOR_CFG, 32'h0001_0005);
        cmd(1'b0, FID_VECTOR_CFG, 32'h5);
        chk("vector readback", res, 32'h0001_0005);
        clr();
        post(1'b0, 1'b0, 3'd5, 1);
        chk("off flag direct", 32'(irq_acc), 32'h20);
        cmd(1'b1, FID_COALESCE, 32'h0000_0005);
        clr();
        post(1'b0, 1'b0, 3'd0, 5);
        // a full tick period passes: a zero time must never fire the held entries
        repeat (2600) @(posedge clk_sys);
        chk("time zero no timer", 32'(irq_acc), 32'h0);
        post(1'b0, 1'b0, 3'd0, 1);
        chk("sixth entry fires", 32'(irq_acc), 32'h1);
        clr();
        // vector 1 still holds two entries; the shared tick releases it before vector 2
        cmd(1'b1, FID_COALESCE, 32'h0000_02ff);
        post(1'b0, 1'b0, 3'd2, 1);
        chk("timer not yet", 32'(irq_acc[2]), 32'h0);
        for (n = 0; n < 5200 && irq_acc[2] !== 1'b1; n++)
            @(posedge clk_sys);
        chk("timer fires", 32'(irq_acc), 32'h6);
        chk("timer not early", 32'(n >= TICK_CYCLES - 2), 32'h1);
        chk("timer bound", 32'(n <= 2 * TICK_CYCLES), 32'h1);
        cmd(1'b1, FID_EVENT_CFG, 32'hffff_ff05);
        cmd(1'b0, FID_EVENT_CFG, 32'h0);
        chk("mask readback", res, 32'h5);
        clr();
        critical_warning <= 8'h07;
        repeat (12) @(posedge clk_sys);
        chk("event bits", 32'(ev_acc), 32'h5);
        cmd(1'b1, 8'h0a, 32'h1);
        host.xfer(1'b0, ADDR_STATUS, 32'h0, res, err);
        chk("bad id", 32'(res[8]), 32'h1);
        host.xfer(1'b0, 12'h020, 32'h0, res, err);
        chk("unmapped", 32'(err), 32'h1);
        report_and_stop();
    end
endmodule // test_completion_coalescer
